//--- rtl/srxirq_regs.sv
// receiver control, routing and sticky interrupt registers on AXI4-Lite
`timescale 1ns/1ns
`include "srxirq_cfg.svh"
module srxirq_regs
   import srxirq_pkg::*;
#(
   parameter int AW    = 8,
   parameter int SMP_W = 24,
   parameter int N_IN  = 8
) (
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // axi4-lite write address
   input  wire logic [AW-1:0]      s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // axi4-lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // axi4-lite read address
   input  wire logic [AW-1:0]      s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   // axi4-lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // receiver input pins and routed outputs
   input  wire logic [N_IN-1:0]    rx_input_pin,
   output logic                    passthru_out_pin,
   output logic                    rx_input_routed,
   // interrupt source conditions from the receiver core
   input  wire srxirq_src_type     irq_src,
   // received channel status of both sides
   input  wire srxirq_cs_info_type cs_info_a,
   input  wire srxirq_cs_info_type cs_info_b,
   // audio sample path
   input  wire logic [SMP_W-1:0]   sample_in,
   input  wire logic               sample_in_valid,
   output logic [SMP_W-1:0]        sample_out,
   output logic                    sample_out_valid,
   // buffer and lock controls to the receiver core
   output logic [1:0]              lock_algorithm_sel,
   output logic                    buffer_content_sel,
   output logic                    cbuf_byte_mode,
   output logic                    subframe_side_sel,
   // interrupt pin, open drain when selected
   output logic                    irq_pin_out,
   output logic                    irq_pin_oe
);

   localparam int SW = $clog2(N_IN);

   // register at index idx
   function automatic logic hit(input logic [AW-1:0] addr,
                                input logic [5:0]    idx);
      hit = (addr[AW-1:2] == (AW-2)'(idx));
   endfunction : hit

   // any mapped index
   function automatic logic mapped(input logic [AW-1:0] addr);
      mapped = hit(addr, `SRXIRQ_IDX_RX_MODE)
             | hit(addr, `SRXIRQ_IDX_ROUTING)
             | hit(addr, `SRXIRQ_IDX_FLAGS)
             | hit(addr, `SRXIRQ_IDX_MASK)
             | hit(addr, `SRXIRQ_IDX_MODE_HI)
             | hit(addr, `SRXIRQ_IDX_MODE_LO)
             | hit(addr, `SRXIRQ_IDX_BUF_CTRL)
             | hit(addr, `SRXIRQ_IDX_RX_STATUS);
   endfunction : mapped

   // control registers
   logic [7:0] rx_mode_r;
   logic [7:0] rx_input_routing_r;
   logic [7:0] irq_enable_mask_r;
   logic [7:0] irq_trigger_mode_hi_r;
   logic [7:0] irq_trigger_mode_lo_r;
   logic [7:0] status_buffer_ctrl_r;
   logic [7:0] irq_flags_r;
   logic [7:0] irq_flags_nxt;

   // write channel state
   logic          awready_r;
   logic          wready_r;
   logic          aw_full_r;
   logic          w_full_r;
   logic [AW-1:0] waddr_r;
   logic [7:0]    wdata_r;
   logic          wstrb0_r;
   logic          bvalid_r;
   logic [1:0]    bresp_r;
   logic          aw_take;
   logic          w_take;
   logic          do_write;
   logic          aw_full_nxt;
   logic          w_full_nxt;
   logic          bvalid_nxt;

   // read channel state
   logic          arready_r;
   logic          rvalid_r;
   logic [31:0]   rdata_r;
   logic [1:0]    rresp_r;
   logic          ar_take;
   logic [7:0]    rd_byte;
   logic          flags_rd_clr;

   // interrupt logic
   logic [7:0]         cond;
   logic [7:0]         cond_prev_r;
   logic [7:0]         irq_event;
   logic               irq_active;
   logic               irq_out_r;
   logic               irq_oe_r;
   srxirq_pin_pol_type pin_pol;
   srxirq_policy_type  policy;
   srxirq_cs_info_type cs_sel;

   // sample path
   logic [SMP_W-1:0] last_good_r;
   logic [SMP_W-1:0] sample_out_r;
   logic             sample_out_valid_r;

   // ---------------- write channel ----------------
   assign aw_take  = s_axi_awvalid & awready_r;
   assign w_take   = s_axi_wvalid & wready_r;
   assign do_write = aw_full_r & w_full_r;

   always_comb begin
      aw_full_nxt = (aw_full_r | aw_take) & ~do_write;
      w_full_nxt  = (w_full_r | w_take) & ~do_write;
      bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `SRXIRQ_RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready_r <= ~aw_full_nxt & ~bvalid_nxt;
         wready_r  <= ~w_full_nxt & ~bvalid_nxt;
         bvalid_r  <= bvalid_nxt;
         if (do_write) begin
            bresp_r <= mapped(waddr_r) ? `SRXIRQ_RESP_OKAY
                                       : `SRXIRQ_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waddr_r  <= '0;
         wdata_r  <= 8'h00;
         wstrb0_r <= 1'b0;
      end else begin
         if (aw_take) begin
            waddr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
      end
   end

   // control registers keep only defined bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_mode_r             <= `SRXIRQ_RST_RX_MODE;
         rx_input_routing_r    <= `SRXIRQ_RST_ROUTING;
         irq_enable_mask_r     <= `SRXIRQ_RST_MASK;
         irq_trigger_mode_hi_r <= `SRXIRQ_RST_MODE;
         irq_trigger_mode_lo_r <= `SRXIRQ_RST_MODE;
         status_buffer_ctrl_r  <= `SRXIRQ_RST_BUF_CTRL;
      end else if (do_write && wstrb0_r) begin
         if (hit(waddr_r, `SRXIRQ_IDX_RX_MODE)) begin
            rx_mode_r <= wdata_r & `SRXIRQ_MASK_RX_MODE;
         end else if (hit(waddr_r, `SRXIRQ_IDX_ROUTING)) begin
            rx_input_routing_r <= wdata_r & `SRXIRQ_MASK_ROUTING;
         end else if (hit(waddr_r, `SRXIRQ_IDX_MASK)) begin
            irq_enable_mask_r <= wdata_r & `SRXIRQ_MASK_IRQ;
         end else if (hit(waddr_r, `SRXIRQ_IDX_MODE_HI)) begin
            irq_trigger_mode_hi_r <= wdata_r & `SRXIRQ_MASK_IRQ;
         end else if (hit(waddr_r, `SRXIRQ_IDX_MODE_LO)) begin
            irq_trigger_mode_lo_r <= wdata_r & `SRXIRQ_MASK_IRQ;
         end else if (hit(waddr_r, `SRXIRQ_IDX_BUF_CTRL)) begin
            status_buffer_ctrl_r <= wdata_r & `SRXIRQ_MASK_BUF_CTRL;
         end
      end
   end

   // ---------------- read channel ----------------
   assign ar_take = s_axi_arvalid & arready_r;
   assign cs_sel  = status_buffer_ctrl_r[`SRXIRQ_POS_CHS] ? cs_info_b
                                                          : cs_info_a;

   always_comb begin
      rd_byte = 8'h00;
      if (hit(s_axi_araddr, `SRXIRQ_IDX_RX_MODE)) begin
         rd_byte = rx_mode_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_ROUTING)) begin
         rd_byte = rx_input_routing_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_FLAGS)) begin
         rd_byte = irq_flags_r & irq_enable_mask_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_MASK)) begin
         rd_byte = irq_enable_mask_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_MODE_HI)) begin
         rd_byte = irq_trigger_mode_hi_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_MODE_LO)) begin
         rd_byte = irq_trigger_mode_lo_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_BUF_CTRL)) begin
         rd_byte = status_buffer_ctrl_r;
      end else if (hit(s_axi_araddr, `SRXIRQ_IDX_RX_STATUS)) begin
         rd_byte = cs_sel;
      end
   end

   assign flags_rd_clr = ar_take & hit(s_axi_araddr, `SRXIRQ_IDX_FLAGS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `SRXIRQ_RESP_OKAY;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= {24'h00_0000, rd_byte};
         rresp_r   <= mapped(s_axi_araddr) ? `SRXIRQ_RESP_OKAY
                                           : `SRXIRQ_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // ---------------- interrupt sources ----------------
   always_comb begin
      cond                         = 8'h00;
      cond[`SRXIRQ_BIT_UNLOCK]     = irq_src.unlock;
      cond[`SRXIRQ_BIT_QSUB]       = irq_src.qsub_block_new;
      cond[`SRXIRQ_BIT_CS_XFER]    = irq_src.cs_buffer_xfer;
      cond[`SRXIRQ_BIT_UB_XFER]    = irq_src.ub_buffer_xfer;
      cond[`SRXIRQ_BIT_OVFL]       = irq_src.adc_overflow;
      cond[`SRXIRQ_BIT_RX_FAULT]   = irq_src.rx_fault_flag;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cond_prev_r <= 8'h00;
      end else begin
         cond_prev_r <= cond;
      end
   end

   // per-source trigger from the two mode registers
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         case (srxirq_trig_type'({irq_trigger_mode_hi_r[i],
                                  irq_trigger_mode_lo_r[i]}))
            TRIG_RISE:  irq_event[i] = cond[i] & ~cond_prev_r[i];
            TRIG_FALL:  irq_event[i] = ~cond[i] & cond_prev_r[i];
            TRIG_LEVEL: irq_event[i] = cond[i];
            default:    irq_event[i] = 1'b0;
         endcase
      end
   end

   // sticky flags; a set beside a clearing read wins
   always_comb begin
      irq_flags_nxt = flags_rd_clr ? 8'h00 : irq_flags_r;
      irq_flags_nxt = (irq_flags_nxt | irq_event)
                    & irq_enable_mask_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_flags_r <= 8'h00;
      end else begin
         irq_flags_r <= irq_flags_nxt;
      end
   end

   // ---------------- interrupt pin ----------------
   assign irq_active = |irq_flags_nxt;
   assign pin_pol    = srxirq_pin_pol_type'(
                          rx_mode_r[`SRXIRQ_POS_PIN_POL +: 2]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out_r <= 1'b0;
         irq_oe_r  <= 1'b1;
      end else begin
         case (pin_pol)
            PIN_ACT_HIGH: begin
               irq_out_r <= irq_active;
               irq_oe_r  <= 1'b1;
            end
            PIN_ACT_LOW: begin
               irq_out_r <= ~irq_active;
               irq_oe_r  <= 1'b1;
            end
            PIN_OPEN_DRAIN: begin
               irq_out_r <= 1'b0;
               irq_oe_r  <= irq_active;
            end
            default: begin
               irq_out_r <= 1'b0;
               irq_oe_r  <= 1'b0;
            end
         endcase
      end
   end

   // ---------------- sample fault policy ----------------
   assign policy = srxirq_policy_type'(rx_mode_r[`SRXIRQ_POS_POLICY +: 2]);

   // fault input is the unmasked, sample-affecting fault only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_good_r        <= '0;
         sample_out_r       <= '0;
         sample_out_valid_r <= 1'b0;
      end else begin
         sample_out_valid_r <= sample_in_valid;
         if (sample_in_valid) begin
            if (!irq_src.rx_fault_flag) begin
               last_good_r  <= sample_in;
               sample_out_r <= sample_in;
            end else begin
               case (policy)
                  POLICY_HOLD: sample_out_r <= last_good_r;
                  POLICY_ZERO: sample_out_r <= '0;
                  default:     sample_out_r <= sample_in;
               endcase
            end
         end
      end
   end

   // ---------------- input routing ----------------
   srxirq_pin_mux #(
      .N_IN (N_IN),
      .SW   (SW)
   ) u_pin_mux (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .rx_input_pin       (rx_input_pin),
      .passthru_input_sel (rx_input_routing_r[`SRXIRQ_POS_PT_SEL +: SW]),
      .rx_input_sel       (rx_input_routing_r[`SRXIRQ_POS_RX_SEL +: SW]),
      .passthru_out_pin   (passthru_out_pin),
      .rx_input_routed    (rx_input_routed)
   );

   // ---------------- outputs ----------------
   assign s_axi_awready      = awready_r;
   assign s_axi_wready       = wready_r;
   assign s_axi_bvalid       = bvalid_r;
   assign s_axi_bresp        = bresp_r;
   assign s_axi_arready      = arready_r;
   assign s_axi_rvalid       = rvalid_r;
   assign s_axi_rdata        = rdata_r;
   assign s_axi_rresp        = rresp_r;
   assign sample_out         = sample_out_r;
   assign sample_out_valid   = sample_out_valid_r;
   assign irq_pin_out        = irq_out_r;
   assign irq_pin_oe         = irq_oe_r;
   assign lock_algorithm_sel = status_buffer_ctrl_r[`SRXIRQ_POS_LOCKM +: 2];
   assign buffer_content_sel = status_buffer_ctrl_r[`SRXIRQ_POS_BUFFER_CONTENT_SEL];
   assign cbuf_byte_mode     = status_buffer_ctrl_r[`SRXIRQ_POS_CAM];
   assign subframe_side_sel  = status_buffer_ctrl_r[`SRXIRQ_POS_CHS];

endmodule : srxirq_regs

//--- rtl/srxirq_cfg.svh
// constants for the receiver control and interrupt register group
`ifndef SRXIRQ_CFG_SVH
`define SRXIRQ_CFG_SVH

// register indices, byte address is four times the index
`define SRXIRQ_IDX_RX_MODE      6'h1E
`define SRXIRQ_IDX_ROUTING      6'h1F
`define SRXIRQ_IDX_FLAGS        6'h20
`define SRXIRQ_IDX_MASK         6'h21
`define SRXIRQ_IDX_MODE_HI      6'h22
`define SRXIRQ_IDX_MODE_LO      6'h23
`define SRXIRQ_IDX_BUF_CTRL     6'h24
`define SRXIRQ_IDX_RX_STATUS    6'h25

// field positions
`define SRXIRQ_POS_POLICY       0
`define SRXIRQ_POS_PIN_POL      2
`define SRXIRQ_POS_RX_SEL       0
`define SRXIRQ_POS_PT_SEL       4
`define SRXIRQ_POS_CHS          0
`define SRXIRQ_POS_CAM          1
`define SRXIRQ_POS_BUFFER_CONTENT_SEL         2
`define SRXIRQ_POS_LOCKM        6

// flag bit positions
`define SRXIRQ_BIT_UNLOCK       7
`define SRXIRQ_BIT_QSUB         5
`define SRXIRQ_BIT_CS_XFER      4
`define SRXIRQ_BIT_UB_XFER      3
`define SRXIRQ_BIT_OVFL         1
`define SRXIRQ_BIT_RX_FAULT     0

// writable bits of each register
`define SRXIRQ_MASK_RX_MODE     8'h0F
`define SRXIRQ_MASK_ROUTING     8'h77
`define SRXIRQ_MASK_IRQ         8'hBB
`define SRXIRQ_MASK_BUF_CTRL    8'hC7

// reset values
`define SRXIRQ_RST_RX_MODE      8'h00
`define SRXIRQ_RST_ROUTING      8'h00
`define SRXIRQ_RST_MASK         8'h00
`define SRXIRQ_RST_MODE         8'h00
`define SRXIRQ_RST_BUF_CTRL     8'h40

// bus responses
`define SRXIRQ_RESP_OKAY        2'h0
`define SRXIRQ_RESP_SLVERR      2'h2

`endif

//--- rtl/srxirq_pkg.sv
// types for the receiver control and interrupt register group
package srxirq_pkg;

   typedef enum logic [1:0] {
      POLICY_HOLD,
      POLICY_ZERO,
      POLICY_PASS,
      POLICY_RSVD
   } srxirq_policy_type;

   typedef enum logic [1:0] {
      TRIG_RISE,
      TRIG_FALL,
      TRIG_LEVEL,
      TRIG_RSVD
   } srxirq_trig_type;

   typedef enum logic [1:0] {
      PIN_ACT_HIGH,
      PIN_ACT_LOW,
      PIN_OPEN_DRAIN,
      PIN_RSVD
   } srxirq_pin_pol_type;

   // interrupt source conditions, all levels
   typedef struct packed {
      logic unlock;
      logic qsub_block_new;
      logic cs_buffer_xfer;
      logic ub_buffer_xfer;
      logic adc_overflow;
      logic rx_fault_flag;
   } srxirq_src_type;

   // received channel status of one subframe side, laid out as the byte
   typedef struct packed {
      logic [3:0] side_bits_len;
      logic       studio_fmt_flag;
      logic       non_audio_flag;
      logic       copyright_flag;
      logic       first_gen_flag;
   } srxirq_cs_info_type;

endpackage : srxirq_pkg

//--- rtl/srxirq_pin_mux.sv
// input pin synchroniser and the two eight-way input selectors
`timescale 1ns/1ns
module srxirq_pin_mux #(
   parameter int N_IN = 8,
   parameter int SW   = $clog2(N_IN)
) (
   // clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // pins
   input  wire logic [N_IN-1:0] rx_input_pin,
   // selects
   input  wire logic [SW-1:0]   passthru_input_sel,
   input  wire logic [SW-1:0]   rx_input_sel,
   // routed outputs
   output logic                 passthru_out_pin,
   output logic                 rx_input_routed
);

   logic [N_IN-1:0] meta_r;
   logic [N_IN-1:0] sync_r;
   logic            passthru_r;
   logic            routed_r;

   // first stage read by second stage only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= rx_input_pin;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         passthru_r <= 1'b0;
         routed_r   <= 1'b0;
      end else begin
         passthru_r <= sync_r[passthru_input_sel];
         routed_r   <= sync_r[rx_input_sel];
      end
   end

   assign passthru_out_pin = passthru_r;
   assign rx_input_routed  = routed_r;

endmodule : srxirq_pin_mux

//--- dv/srxirq_host.sv
// host model driving the register port
`timescale 1ns/1ns
module srxirq_host (
   // clock
   input  wire logic        aclk,
   // write channels
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // read channels
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
      s_axi_rready = 1'b0;
   end
   task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : srxirq_host

//--- dv/srxirq_asserts.sv
// port assertions for the register group
`timescale 1ns/1ns
module srxirq_asserts
   import srxirq_pkg::*;
#(
   parameter int SMP_W = 24
) (
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // bus
   input  wire logic               s_axi_awvalid,
   input  wire logic               s_axi_awready,
   input  wire logic               s_axi_wvalid,
   input  wire logic               s_axi_wready,
   input  wire logic               s_axi_bvalid,
   input  wire logic               s_axi_arvalid,
   input  wire logic               s_axi_arready,
   input  wire logic [31:0]        s_axi_rdata,
   input  wire logic [1:0]         s_axi_rresp,
   input  wire logic               s_axi_rvalid,
   // core side
   input  wire srxirq_src_type     irq_src,
   input  wire logic [SMP_W-1:0]   sample_in,
   input  wire logic               sample_in_valid,
   input  wire logic [SMP_W-1:0]   sample_out,
   input  wire logic               sample_out_valid,
   input  wire logic [1:0]         lock_algorithm_sel
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_ar_busy;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken twice");
   property p_r_hi;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_r_hi: assert property (p_r_hi) else $error("upper data set");
   property p_r_err;
      s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000;
   endproperty
   a_r_err: assert property (p_r_err) else $error("error read data");
   property p_smp_lat;
      sample_in_valid |=> sample_out_valid;
   endproperty
   a_smp_lat: assert property (p_smp_lat) else $error("sample late");
   property p_smp_pass;
      sample_in_valid && !irq_src.rx_fault_flag
         |=> sample_out == $past(sample_in);
   endproperty
   a_smp_pass: assert property (p_smp_pass) else $error("good sample lost");
   property p_lock_rst;
      $rose(aresetn) |-> lock_algorithm_sel == 2'h1;
   endproperty
   a_lock_rst: assert property (p_lock_rst) else $error("lock reset bad");
   c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_fault: cover property (sample_in_valid && irq_src.rx_fault_flag);
   c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule : srxirq_asserts
bind srxirq_regs srxirq_asserts #(.SMP_W(SMP_W)) srxirq_asserts_inst (.*);

//--- dv/tb.sv
// self-checking bench for the register group
`timescale 1ns/1ns
module tb;
   import srxirq_pkg::*;
   logic               aclk, aresetn, s_axi_awvalid, s_axi_awready;
   logic [7:0]         s_axi_awaddr, s_axi_araddr, rx_input_pin;
   logic [31:0]        s_axi_wdata, s_axi_rdata;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp, lock_algorithm_sel, r;
   logic               s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic               s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic               s_axi_rvalid, s_axi_rready, passthru_out_pin;
   logic               rx_input_routed, buffer_content_sel;
   logic               cbuf_byte_mode, subframe_side_sel, irq_pin_out;
   logic               irq_pin_oe, sample_in_valid, sample_out_valid;
   logic [23:0]        sample_in, sample_out, g, f;
   srxirq_src_type     irq_src;
   srxirq_cs_info_type cs_info_a, cs_info_b;
   logic [9:0]         q[$];
   int                 fails, n_compared;
   srxirq_regs srxirq_regs_inst (.*);
   srxirq_host srxirq_host_inst (.*);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] gv, input logic [31:0] e);
      n_compared++;
      if (gv !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, gv, e);
      end
   endtask : chk
   task rx(input logic [7:0] a, input logic [9:0] e);
      q.push_back(e);
      srxirq_host_inst.rd(a);
   endtask : rx
   task wr(input logic [7:0] a, input logic [7:0] d);
      srxirq_host_inst.wr(a, d, r);
   endtask : wr
   task smp(input logic [23:0] d, input logic fl, input logic [23:0] e);
      @(posedge aclk);
      sample_in <= d;
      sample_in_valid <= 1'b1;
      irq_src <= srxirq_src_type'({5'h00, fl});
      @(posedge aclk);
      sample_in_valid <= 1'b0;
      irq_src <= '0;
      #1 chk(32'({sample_out_valid, sample_out}), 32'({1'b1, e}));
   endtask : smp
   task print_verdict;
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         chk(32'({s_axi_rresp, s_axi_rdata[7:0]}), 32'(q.pop_front()));
   end
   initial begin
      #200000;
      fails++;
      print_verdict;
   end
   initial begin
      {aresetn, irq_src, rx_input_pin, sample_in, sample_in_valid} = '0;
      {cs_info_a, cs_info_b} = '0;
      void'($urandom(92090));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rx(8'h84, 10'h000);
      rx(8'h88, 10'h000);
      rx(8'h8C, 10'h000);
      rx(8'h90, 10'h040);
      rx(8'h40, 10'h200);
      wr(8'h40, 8'hFF);
      chk(32'(r), 32'h2);
      wr(8'h84, 8'hFF);
      rx(8'h84, 10'h0BB);
      wr(8'h88, 8'h01);
      wr(8'h8C, 8'h20);
      rx(8'h80, 10'h000);
      @(posedge aclk) irq_src <= 6'h20;
      @(posedge aclk) irq_src <= 6'h11;
      @(posedge aclk) irq_src <= 6'h10;
      rx(8'h80, 10'h081);
      @(posedge aclk) irq_src <= '0;
      rx(8'h80, 10'h020);
      rx(8'h80, 10'h000);
      wr(8'h84, 8'hAB);
      @(posedge aclk) irq_src <= 6'h0E;
      @(posedge aclk) irq_src <= '0;
      // pin per polarity, flags pending in the first four, clear after
      for (int p = 0; p < 8; p++) begin
         if (p == 4) rx(8'h80, 10'h00A);
         wr(8'h78, 8'((p % 4) << 2));
         repeat (2) @(posedge aclk);
         #1 chk(32'({irq_pin_oe, irq_pin_out}),
                32'((16'h0E2B >> (2 * p)) & 16'h0003));
      end
      for (int p = 0; p < 4; p++) begin
         g = 24'($urandom);
         f = 24'($urandom);
         wr(8'h78, 8'(p));
         smp(g, 1'b0, g);
         smp(f, 1'b1, (p == 0) ? g : (p == 1) ? 24'h000000 : f);
      end
      for (int i = 0; i < 8; i++) begin
         wr(8'h7C, 8'((i << 4) | (7 - i)));
         rx_input_pin <= 8'($urandom);
         repeat (4) @(posedge aclk);
         #1 chk(32'({passthru_out_pin, rx_input_routed}),
                32'({rx_input_pin[i], rx_input_pin[7-i]}));
      end
      cs_info_a <= srxirq_cs_info_type'(8'($urandom));
      cs_info_b <= srxirq_cs_info_type'(8'($urandom));
      wr(8'h90, 8'hFF);
      rx(8'h90, 10'h0C7);
      rx(8'h94, {2'h0, cs_info_b});
      chk(32'({lock_algorithm_sel, buffer_content_sel, cbuf_byte_mode,
               subframe_side_sel}), 32'h1F);
      wr(8'h90, 8'h80);
      rx(8'h94, {2'h0, cs_info_a});
      chk(32'({lock_algorithm_sel, buffer_content_sel, cbuf_byte_mode,
               subframe_side_sel}), 32'h10);
      @(posedge aclk);
      print_verdict;
   end
endmodule : tb
